// File: inc/imf_cfg.svh
`ifndef IMF_CFG_SVH
`define IMF_CFG_SVH
// register offsets, shared by the two register spaces where names match
`define IMF_OFS_INT_STATUS     8'h0A
`define IMF_OFS_FILL_OVR       8'h0E
`define IMF_OFS_GYRO_IRQ_EN    8'h15
`define IMF_OFS_ACC_IRQ_EN     8'h17
`define IMF_OFS_GYRO_PIN_MAP   8'h18
`define IMF_OFS_ACC_PIN_MAP    8'h1A
`define IMF_OFS_GYRO_WM_EN     8'h1E
`define IMF_OFS_ACC_WM_LEVEL   8'h30
`define IMF_OFS_SYNC_CFG       8'h34
`define IMF_OFS_GYRO_WM_LEVEL  8'h3D
`define IMF_OFS_QUEUE_CFG      8'h3E
// field positions
`define IMF_BIT_SYNC_EN        5
`define IMF_BIT_SYNC_SEL       4
`define IMF_BIT_OVERRUN        7
`define IMF_BIT_ACC_WM_EN      6
`define IMF_BIT_ACC_FULL_EN    5
`define IMF_BIT_ACC_WM_P1      1
`define IMF_BIT_ACC_WM_P2      6
`define IMF_BIT_ACC_FULL_P1    2
`define IMF_BIT_ACC_FULL_P2    5
`define IMF_BIT_GYRO_WM_EN     7
`define IMF_BIT_GYRO_Q_EN      6
`define IMF_BIT_GYRO_Q_P1      2
`define IMF_BIT_GYRO_Q_P2      5
`define IMF_BIT_ACC_WM_ST      6
`define IMF_BIT_ACC_FULL_ST    5
`define IMF_BIT_GYRO_Q_ST      4
`define IMF_MODE_HI            7
`define IMF_MODE_LO            6
// capacities in frames for stop-when-full mode
`define IMF_ACC_CAP            7'h20
`define IMF_GYRO_CAP           7'h64
// reset value of every writable register
`define IMF_REG_RESET          8'h00
`endif

// File: inc/imf_pkg.sv
package imf_pkg;
   // queue operating mode field encodings
   typedef enum logic [1:0] {
      IMF_BYPASS = 2'h0,
      IMF_STOP   = 2'h1,
      IMF_STREAM = 2'h2,
      IMF_RSVD   = 2'h3
   } imf_mode_e;
endpackage

// File: design/imf_level.sv
`timescale 1ns/10ps
`default_nettype none
`include "imf_cfg.svh"
// fill level and overrun tracking for one sample queue
module imf_level
#(
   parameter logic [6:0] CAP = 7'h20
)
(
   input  wire logic            ref_clk,
   input  wire logic            srst,
   input  wire logic            clr,
   input  wire logic            push,
   input  wire logic            pop,
   input  wire imf_pkg::imf_mode_e mode,
   output logic          [6:0]  count_r,
   output logic                 overrun_r,
   output logic                 full
);
   // capacity for the active mode; reserved acts like bypass
   function automatic logic [6:0] cap_of(input imf_pkg::imf_mode_e m);
      unique case (m)
         imf_pkg::IMF_STOP:   cap_of = CAP;
         imf_pkg::IMF_STREAM: cap_of = CAP - 7'h01;
         default:             cap_of = 7'h01;
      endcase
   endfunction

   logic [6:0] count_nxt;   // next fill level

   assign full = (count_r >= cap_of(mode));

   // full drops the push in every mode, stop, stream and bypass alike
   always_comb
   begin
      count_nxt = count_r;
      if (push && !full)
         count_nxt = count_nxt + 7'h01;
      if (pop && (count_r != 7'h00))
         count_nxt = count_nxt - 7'h01;
   end

   // fill level register, cleared by configuration writes
   always_ff @(posedge ref_clk)
   begin
      if (srst || clr)
         count_r <= 7'h00;
      else
         count_r <= count_nxt;
   end

   // overrun stays set through reads that drain the queue
   always_ff @(posedge ref_clk)
   begin
      if (srst || clr)
         overrun_r <= 1'b0;
      else if (push && full)
         overrun_r <= 1'b1;
   end
endmodule
`default_nettype wire

// File: design/imf_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "imf_cfg.svh"
module imf_top
(
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        reg_gyro_sel,
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata_r,
   input  wire logic        acc_sample_stb,
   input  wire logic        acc_frame_pop,
   input  wire logic        gyro_sample_stb,
   input  wire logic [15:0] gyro_z_in,
   input  wire logic        gyro_frame_pop,
   output logic      [15:0] gyro_z_word_r,
   output logic             gyro_z_valid_r,
   output logic             acc_irq_pin_one_r,
   output logic             acc_irq_pin_two_r,
   input  wire logic        gyro_irq_pin_one_in,
   output logic             gyro_irq_pin_one_out_r,
   output logic             gyro_irq_pin_one_oe_r,
   input  wire logic        gyro_irq_pin_two_in,
   output logic             gyro_irq_pin_two_out_r,
   output logic             gyro_irq_pin_two_oe_r
);
   // writable registers, accelerometer space
   logic [7:0] acc_irq_enable_r;      // enables
   logic [7:0] acc_irq_pin_map_r;     // pin routing
   logic [7:0] acc_watermark_level_r; // watermark level
   logic [7:0] acc_queue_cfg_r;       // mode and data select
   // writable registers, gyroscope space
   logic [7:0] gyro_irq_enable_r;
   logic [7:0] gyro_irq_pin_map_r;
   logic [7:0] gyro_wm_irq_enable_r;
   logic [7:0] gyro_sync_config_r;
   logic [7:0] gyro_watermark_level_r;
   logic [7:0] gyro_queue_cfg_r;

   // queue state from the level trackers
   logic [6:0] acc_count;
   logic [6:0] gyro_count;
   logic       acc_overrun;
   logic       gyro_overrun;
   logic       acc_full;
   logic       gyro_full;
   logic       acc_clr;     // clear pulse for accelerometer queue
   logic       gyro_clr;    // clear pulse for gyroscope queue

   // sync pin synchronisers
   logic       pin_one_s1_r;
   logic       pin_one_s2_r;
   logic       pin_two_s1_r;
   logic       pin_two_s2_r;

   // decoded controls and events
   imf_pkg::imf_mode_e acc_mode;
   imf_pkg::imf_mode_e gyro_mode;
   logic       external_sync_tag;  // sync mode enabled
   logic       sync_sel_two;       // sync on pin two
   logic       tag_allowed;
   logic       sync_level;
   logic       acc_wm;
   logic       gyro_wm;
   logic       gyro_queue_int;
   logic       acc_wm_status;
   logic [7:0] rdata_nxt;

   // register write decoded against one space
   function automatic logic wr_hit(input logic gyro, input logic [7:0] ofs);
      wr_hit = reg_wr_en && (reg_gyro_sel == gyro) && (reg_addr == ofs);
   endfunction

   assign acc_mode  = imf_pkg::imf_mode_e'(
      acc_queue_cfg_r[`IMF_MODE_HI:`IMF_MODE_LO]);
   assign gyro_mode = imf_pkg::imf_mode_e'(
      gyro_queue_cfg_r[`IMF_MODE_HI:`IMF_MODE_LO]);

   // configuration or watermark writes empty the queue; a process, not an
   // assign, so the bus signals read inside wr_hit wake it up
   always_comb
   begin
      acc_clr  = wr_hit(1'b0, `IMF_OFS_QUEUE_CFG)
              || wr_hit(1'b0, `IMF_OFS_ACC_WM_LEVEL);
      gyro_clr = wr_hit(1'b1, `IMF_OFS_QUEUE_CFG)
              || wr_hit(1'b1, `IMF_OFS_GYRO_WM_LEVEL);
   end

   // accelerometer register writes
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         acc_irq_enable_r      <= `IMF_REG_RESET;
         acc_irq_pin_map_r     <= `IMF_REG_RESET;
         acc_watermark_level_r <= `IMF_REG_RESET;
         acc_queue_cfg_r       <= `IMF_REG_RESET;
      end
      else
      begin
         if (wr_hit(1'b0, `IMF_OFS_ACC_IRQ_EN))
            acc_irq_enable_r <= reg_wdata;
         if (wr_hit(1'b0, `IMF_OFS_ACC_PIN_MAP))
            acc_irq_pin_map_r <= reg_wdata;
         if (wr_hit(1'b0, `IMF_OFS_ACC_WM_LEVEL))
            acc_watermark_level_r <= reg_wdata;
         if (wr_hit(1'b0, `IMF_OFS_QUEUE_CFG))
            acc_queue_cfg_r <= reg_wdata;
      end
   end

   // gyroscope register writes
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         gyro_irq_enable_r      <= `IMF_REG_RESET;
         gyro_irq_pin_map_r     <= `IMF_REG_RESET;
         gyro_wm_irq_enable_r   <= `IMF_REG_RESET;
         gyro_sync_config_r     <= `IMF_REG_RESET;
         gyro_watermark_level_r <= `IMF_REG_RESET;
         gyro_queue_cfg_r       <= `IMF_REG_RESET;
      end
      else
      begin
         if (wr_hit(1'b1, `IMF_OFS_GYRO_IRQ_EN))
            gyro_irq_enable_r <= reg_wdata;
         if (wr_hit(1'b1, `IMF_OFS_GYRO_PIN_MAP))
            gyro_irq_pin_map_r <= reg_wdata;
         if (wr_hit(1'b1, `IMF_OFS_GYRO_WM_EN))
            gyro_wm_irq_enable_r <= reg_wdata;
         if (wr_hit(1'b1, `IMF_OFS_SYNC_CFG))
            gyro_sync_config_r <= reg_wdata;
         if (wr_hit(1'b1, `IMF_OFS_GYRO_WM_LEVEL))
            gyro_watermark_level_r <= reg_wdata;
         if (wr_hit(1'b1, `IMF_OFS_QUEUE_CFG))
            gyro_queue_cfg_r <= reg_wdata;
      end
   end

   // fill level trackers, one per sensor
   imf_level #(.CAP(`IMF_ACC_CAP)) u_acc_level
   (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .clr       (acc_clr),
      .push      (acc_sample_stb),
      .pop       (acc_frame_pop),
      .mode      (acc_mode),
      .count_r   (acc_count),
      .overrun_r (acc_overrun),
      .full      (acc_full)
   );

   imf_level #(.CAP(`IMF_GYRO_CAP)) u_gyro_level
   (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .clr       (gyro_clr),
      .push      (gyro_sample_stb),
      .pop       (gyro_frame_pop),
      .mode      (gyro_mode),
      .count_r   (gyro_count),
      .overrun_r (gyro_overrun),
      .full      (gyro_full)
   );

   // interrupt events; a zero level never counts as reached
   assign acc_wm  = (acc_watermark_level_r[5:0] != 6'h00)
                 && ({1'b0, acc_count} >= {2'b00, acc_watermark_level_r[5:0]});
   assign gyro_wm = (gyro_watermark_level_r[6:0] != 7'h00)
                 && (gyro_count >= gyro_watermark_level_r[6:0]);
   assign gyro_queue_int = gyro_wm || gyro_full;
   assign acc_wm_status  = acc_wm;

   // sync controls
   assign external_sync_tag = gyro_sync_config_r[`IMF_BIT_SYNC_EN];
   assign sync_sel_two      = gyro_sync_config_r[`IMF_BIT_SYNC_SEL];
   assign tag_allowed = external_sync_tag
                     && ((gyro_mode == imf_pkg::IMF_STOP)
                      || (gyro_mode == imf_pkg::IMF_STREAM));
   assign sync_level  = sync_sel_two ? pin_two_s2_r : pin_one_s2_r;

   // two-stage synchronisers for both gyro pins
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pin_one_s1_r <= 1'b0;
         pin_one_s2_r <= 1'b0;
         pin_two_s1_r <= 1'b0;
         pin_two_s2_r <= 1'b0;
      end
      else
      begin
         pin_one_s1_r <= gyro_irq_pin_one_in;
         pin_one_s2_r <= pin_one_s1_r;
         pin_two_s1_r <= gyro_irq_pin_two_in;
         pin_two_s2_r <= pin_two_s1_r;
      end
   end

   // z word stored; with sync enabled, in stop and stream modes bit 0 takes the synchronised pin level, sampled two edges before this update
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         gyro_z_word_r  <= 16'h0000;
         gyro_z_valid_r <= 1'b0;
      end
      else
      begin
         gyro_z_valid_r <= gyro_sample_stb;
         if (gyro_sample_stb)
         begin
            if (tag_allowed)
               gyro_z_word_r <= {gyro_z_in[15:1], sync_level};
            else
               gyro_z_word_r <= gyro_z_in;
         end
      end
   end

   // accelerometer interrupt pins
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         acc_irq_pin_one_r <= 1'b0;
         acc_irq_pin_two_r <= 1'b0;
      end
      else
      begin
         acc_irq_pin_one_r <=
            (acc_wm && acc_irq_enable_r[`IMF_BIT_ACC_WM_EN]
                    && acc_irq_pin_map_r[`IMF_BIT_ACC_WM_P1])
         || (acc_full && acc_irq_enable_r[`IMF_BIT_ACC_FULL_EN]
                      && acc_irq_pin_map_r[`IMF_BIT_ACC_FULL_P1]);
         acc_irq_pin_two_r <=
            (acc_wm && acc_irq_enable_r[`IMF_BIT_ACC_WM_EN]
                    && acc_irq_pin_map_r[`IMF_BIT_ACC_WM_P2])
         || (acc_full && acc_irq_enable_r[`IMF_BIT_ACC_FULL_EN]
                      && acc_irq_pin_map_r[`IMF_BIT_ACC_FULL_P2]);
      end
   end

   // gyro pins: the sync pin stops driving, the other keeps its role
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         gyro_irq_pin_one_out_r <= 1'b0;
         gyro_irq_pin_one_oe_r  <= 1'b1;
         gyro_irq_pin_two_out_r <= 1'b0;
         gyro_irq_pin_two_oe_r  <= 1'b1;
      end
      else
      begin
         gyro_irq_pin_one_out_r <= gyro_queue_int
            && gyro_wm_irq_enable_r[`IMF_BIT_GYRO_WM_EN]
            && gyro_irq_enable_r[`IMF_BIT_GYRO_Q_EN]
            && gyro_irq_pin_map_r[`IMF_BIT_GYRO_Q_P1];
         gyro_irq_pin_two_out_r <= gyro_queue_int
            && gyro_wm_irq_enable_r[`IMF_BIT_GYRO_WM_EN]
            && gyro_irq_enable_r[`IMF_BIT_GYRO_Q_EN]
            && gyro_irq_pin_map_r[`IMF_BIT_GYRO_Q_P2];
         gyro_irq_pin_one_oe_r <= !(external_sync_tag && !sync_sel_two);
         gyro_irq_pin_two_oe_r <= !(external_sync_tag && sync_sel_two);
      end
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (!reg_gyro_sel)
      begin
         unique case (reg_addr)
            `IMF_OFS_INT_STATUS:
            begin
               rdata_nxt[`IMF_BIT_ACC_WM_ST]   = acc_wm_status;
               rdata_nxt[`IMF_BIT_ACC_FULL_ST] = acc_full;
            end
            `IMF_OFS_FILL_OVR:     rdata_nxt = {acc_overrun, acc_count};
            `IMF_OFS_ACC_IRQ_EN:   rdata_nxt = acc_irq_enable_r;
            `IMF_OFS_ACC_PIN_MAP:  rdata_nxt = acc_irq_pin_map_r;
            `IMF_OFS_ACC_WM_LEVEL: rdata_nxt = acc_watermark_level_r;
            `IMF_OFS_QUEUE_CFG:    rdata_nxt = acc_queue_cfg_r;
            default:               rdata_nxt = 8'h00;
         endcase
      end
      else
      begin
         unique case (reg_addr)
            `IMF_OFS_INT_STATUS:
               rdata_nxt[`IMF_BIT_GYRO_Q_ST] = gyro_queue_int;
            `IMF_OFS_FILL_OVR:
               rdata_nxt = {gyro_overrun, gyro_count};
            `IMF_OFS_GYRO_IRQ_EN:   rdata_nxt = gyro_irq_enable_r;
            `IMF_OFS_GYRO_PIN_MAP:  rdata_nxt = gyro_irq_pin_map_r;
            `IMF_OFS_GYRO_WM_EN:    rdata_nxt = gyro_wm_irq_enable_r;
            `IMF_OFS_SYNC_CFG:      rdata_nxt = gyro_sync_config_r;
            `IMF_OFS_GYRO_WM_LEVEL: rdata_nxt = gyro_watermark_level_r;
            `IMF_OFS_QUEUE_CFG:     rdata_nxt = gyro_queue_cfg_r;
            default:                rdata_nxt = 8'h00;
         endcase
      end
   end

   // read data register, loaded on a read strobe
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         reg_rdata_r <= 8'h00;
      else if (reg_rd_en)
         reg_rdata_r <= rdata_nxt;
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence gyro_cfg_write_s;
      wr_hit(1'b1, `IMF_OFS_QUEUE_CFG);
   endsequence
   sequence gyro_empty_s;
      (gyro_count == 7'h00) && !gyro_overrun;
   endsequence

   cfg_write_clears_a: assert property (gyro_cfg_write_s |=> gyro_empty_s)
      else $error("gyro queue not cleared by config write");
   overrun_on_full_a: assert property
      (gyro_sample_stb && gyro_full && !gyro_clr |=> gyro_overrun)
      else $error("overrun not set on push while full");
   overrun_sticky_a: assert property
      (gyro_overrun && !gyro_clr |=> gyro_overrun)
      else $error("overrun dropped without config write");
   tag_follows_sync_a: assert property
      (gyro_sample_stb && tag_allowed && sync_level
         |=> gyro_z_valid_r && gyro_z_word_r[0])
      else $error("word not tagged while sync high");
   bypass_no_tag_a: assert property
      (gyro_sample_stb && (gyro_mode == imf_pkg::IMF_BYPASS)
         |=> gyro_z_word_r == $past(gyro_z_in))
      else $error("bypass word altered");
   sync_pin_oe_a: assert property
      (##1 $past(external_sync_tag)
         |-> !(gyro_irq_pin_one_oe_r && gyro_irq_pin_two_oe_r))
      else $error("sync pin still driven");
   acc_full_count_a: assert property
      ((acc_mode == imf_pkg::IMF_STOP) |-> (acc_full == (acc_count == 7'h20)))
      else $error("acc full level wrong");
   gyro_full_count_a: assert property
      ((gyro_mode == imf_pkg::IMF_STREAM)
         |-> (gyro_full == (gyro_count == 7'h63)))
      else $error("gyro full level wrong");
endmodule
`default_nettype wire

// File: tb/imf_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host on the register port: one byte per strobe
module imf_host_model
(
   input  wire logic       ref_clk,
   output logic            sel,
   output logic            wr_en,
   output logic            rd_en,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   input  wire logic [7:0] rdata
);
   // serial clock kept at the rate that serves every data rate
   localparam int SCL_KHZ = 400;
   // idle bus at time zero
   initial
   begin
      sel = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end
   // one transfer: strobe held up to the taking edge, answer taken there
   task automatic xfer(input logic s, input logic w,
                       input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge ref_clk);
      #1;
      sel = s;
      addr = a;
      wdata = d;
      wr_en = w;
      rd_en = ~w;
      @(posedge ref_clk);
      #1;
      q = rdata;
      wr_en = 1'b0;
      rd_en = 1'b0;
      // released lines show no stale value
      addr = ~a;
      wdata = ~d;
   endtask
endmodule
`default_nettype wire

// File: tb/imf_fifo_sync_tag_and_irq_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "imf_cfg.svh"
module imf_fifo_sync_tag_and_irq_bench;
   localparam logic [7:0] QC = `IMF_OFS_QUEUE_CFG;  // mode register
   localparam logic [7:0] ST = `IMF_OFS_INT_STATUS; // status register
   localparam logic [7:0] FL = `IMF_OFS_FILL_OVR;   // fill and overrun
   logic        ref_clk = 1'b0;  // main clock
   logic        sync_clk = 1'b0; // clock of the external event source
   logic        srst = 1'b1;     // reset
   logic [3:0]  stb = 4'h0;      // acc push, gyro push, acc pop, gyro pop
   logic [15:0] gz = 16'h0000;   // gyro z input
   logic        ext1 = 1'b0;     // external drive on gyro pin one
   logic        ext2 = 1'b0;     // external drive on gyro pin two
   logic        hs, hw, hr;      // host select and strobes
   logic [7:0]  ha, hd, rdata;   // host address, data, read data
   logic [15:0] gw;              // stored z word
   logic        gv, a1, a2;      // z valid, acc pins
   logic        g1o, g1e, g2o, g2e; // gyro pin drives and enables
   wire         p1 = g1e ? g1o : ext1; // resolved pin one level
   wire         p2 = g2e ? g2o : ext2; // resolved pin two level
   int          err_count = 0;
   int          n_compared = 0;
   // main clock, 8 ns period
   always #4 ref_clk = ~ref_clk;
   // event source clock, 160 ns, phase unrelated to the main clock
   initial
   begin
      #2.5;
      forever #80 sync_clk = ~sync_clk;
   end
   imf_host_model host
   (
      .ref_clk (ref_clk), .sel (hs), .wr_en (hw), .rd_en (hr),
      .addr (ha), .wdata (hd), .rdata (rdata)
   );
   imf_top dut
   (
      .ref_clk (ref_clk), .srst (srst), .reg_gyro_sel (hs),
      .reg_wr_en (hw), .reg_rd_en (hr), .reg_addr (ha),
      .reg_wdata (hd), .reg_rdata_r (rdata),
      .acc_sample_stb (stb[0]), .acc_frame_pop (stb[2]),
      .gyro_sample_stb (stb[1]), .gyro_z_in (gz),
      .gyro_frame_pop (stb[3]), .gyro_z_word_r (gw),
      .gyro_z_valid_r (gv), .acc_irq_pin_one_r (a1),
      .acc_irq_pin_two_r (a2), .gyro_irq_pin_one_in (p1),
      .gyro_irq_pin_one_out_r (g1o), .gyro_irq_pin_one_oe_r (g1e),
      .gyro_irq_pin_two_in (p2), .gyro_irq_pin_two_out_r (g2o),
      .gyro_irq_pin_two_oe_r (g2e)
   );
   // verdict and end of run
   task end_sim;
      if (err_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // compare and count
   task chk(input logic [15:0] got, input logic [15:0] e, input string m);
      n_compared++;
      if (got !== e)
      begin
         $display("BAD %0t %s", $time, m);
         err_count++;
      end
   endtask
   // let n edges pass, then step off the edge
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // register write plus a settling cycle
   task wr(input logic s, input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.xfer(s, 1'b1, a, d, q);
      cyc(1);
   endtask
   // register read and compare
   task rchk(input logic s, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      host.xfer(s, 1'b0, a, 8'h00, q);
      chk({8'h00, q}, {8'h00, e}, "register read");
   endtask
   // n back-to-back pulses on one strobe
   task pulse(input int k, input int n);
      @(posedge ref_clk);
      #1;
      stb[k] = 1'b1;
      cyc(n);
      stb[k] = 1'b0;
   endtask
   // one gyro sample, stored word judged one cycle later
   task gs(input logic [15:0] z, input logic [15:0] e);
      @(posedge ref_clk);
      #1;
      gz = z;
      stb[1] = 1'b1;
      cyc(1);
      stb[1] = 1'b0;
      gz = ~z;
      chk({15'h0000, gv}, 16'h0001, "z valid");
      chk(gw, e, "z word");
   endtask
   // reset state, unmapped and read-only places
   task t_reset;
      rchk(1'b1, FL, 8'h00);
      rchk(1'b1, QC, 8'h00);
      chk({15'h0000, g1e}, 16'h0001, "pin one oe");
      wr(1'b0, 8'h55, 8'hA5);
      rchk(1'b0, 8'h55, 8'h00);
      wr(1'b0, FL, 8'hFF);
      rchk(1'b0, FL, 8'h00);
   endtask
   // gyro stop mode: full at 100, overrun, drain, clear by config write
   task t_gyro_stop;
      wr(1'b1, QC, 8'h40);
      rchk(1'b1, QC, 8'h40);
      pulse(1, 99);
      rchk(1'b1, ST, 8'h00);
      pulse(1, 1);
      rchk(1'b1, ST, 8'h10);
      rchk(1'b1, FL, 8'h64);
      pulse(1, 1);
      rchk(1'b1, FL, 8'hE4);
      pulse(3, 100);
      rchk(1'b1, FL, 8'h80);
      wr(1'b1, QC, 8'h40);
      rchk(1'b1, FL, 8'h00);
      rchk(1'b1, ST, 8'h00);
      wr(1'b1, QC, 8'h80);
      pulse(1, 98);
      rchk(1'b1, ST, 8'h00);
      pulse(1, 1);
      rchk(1'b1, ST, 8'h10);
      wr(1'b1, QC, 8'h00);
      pulse(1, 1);
      rchk(1'b1, ST, 8'h10);
   endtask
   // acc stream full at 31, bypass full and watermark at 1
   task t_acc_modes;
      wr(1'b0, QC, 8'h80);
      pulse(0, 30);
      rchk(1'b0, ST, 8'h00);
      pulse(0, 1);
      rchk(1'b0, ST, 8'h20);
      pulse(0, 1);
      rchk(1'b0, FL, 8'h9F);
      wr(1'b0, QC, 8'h00);
      rchk(1'b0, FL, 8'h00);
      pulse(0, 1);
      rchk(1'b0, ST, 8'h20);
      wr(1'b0, `IMF_OFS_ACC_WM_LEVEL, 8'h01);
      pulse(0, 1);
      rchk(1'b0, ST, 8'h60);
      wr(1'b0, QC, 8'hC0);
      rchk(1'b0, QC, 8'hC0);
      pulse(0, 1);
      rchk(1'b0, ST, 8'h60);
   endtask
   // acc enables, routing and watermark level
   task t_acc_pins;
      wr(1'b0, `IMF_OFS_ACC_IRQ_EN, 8'h40);
      wr(1'b0, `IMF_OFS_ACC_PIN_MAP, 8'h02);
      wr(1'b0, `IMF_OFS_ACC_WM_LEVEL, 8'h03);
      wr(1'b0, QC, 8'h40);
      pulse(0, 2);
      cyc(3);
      chk({15'h0000, a1}, 16'h0000, "acc pin early");
      pulse(0, 1);
      cyc(3);
      chk({14'h0000, a2, a1}, 16'h0001, "acc wm pin");
      rchk(1'b0, ST, 8'h40);
      wr(1'b0, `IMF_OFS_ACC_WM_LEVEL, 8'h03);
      rchk(1'b0, FL, 8'h00);
      wr(1'b0, `IMF_OFS_ACC_IRQ_EN, 8'h20);
      wr(1'b0, `IMF_OFS_ACC_PIN_MAP, 8'h20);
      pulse(0, 32);
      cyc(3);
      chk({14'h0000, a2, a1}, 16'h0002, "acc full pin");
      wr(1'b0, `IMF_OFS_ACC_IRQ_EN, 8'h60);
      wr(1'b0, `IMF_OFS_ACC_PIN_MAP, 8'h44);
      cyc(3);
      chk({14'h0000, a2, a1}, 16'h0003, "acc both pins");
   endtask
   // gyro pin needs watermark enable, queue enable and a route
   task t_gyro_pins;
      wr(1'b1, QC, 8'h40);
      wr(1'b1, `IMF_OFS_GYRO_WM_LEVEL, 8'h02);
      wr(1'b1, `IMF_OFS_GYRO_WM_EN, 8'h80);
      wr(1'b1, `IMF_OFS_GYRO_PIN_MAP, 8'h04);
      pulse(1, 2);
      cyc(3);
      chk({15'h0000, g1o}, 16'h0000, "gyro pin gated");
      rchk(1'b1, ST, 8'h10);
      wr(1'b1, `IMF_OFS_GYRO_IRQ_EN, 8'h40);
      cyc(3);
      chk({15'h0000, g1o}, 16'h0001, "gyro pin one");
      wr(1'b1, `IMF_OFS_GYRO_PIN_MAP, 8'h20);
      cyc(3);
      chk({14'h0000, g2o, g1o}, 16'h0002, "gyro pin two");
      wr(1'b1, `IMF_OFS_GYRO_WM_EN, 8'h00);
      cyc(3);
      chk({15'h0000, g2o}, 16'h0000, "gyro wm off");
   endtask
   // external sync tagging of the z word
   task t_sync;
      wr(1'b1, QC, 8'h80);
      wr(1'b1, `IMF_OFS_SYNC_CFG, 8'h20);
      cyc(2);
      chk({14'h0000, g2e, g1e}, 16'h0002, "sync pin one");
      @(posedge sync_clk);
      #1;
      ext1 = 1'b1;
      cyc(5);
      gs(16'h1234, 16'h1235);
      gs(16'h1234, 16'h1235);
      @(posedge sync_clk);
      #1;
      ext1 = 1'b0;
      cyc(5);
      gs(16'h1234, 16'h1234);
      gs(16'h1235, 16'h1234);
      @(posedge sync_clk);
      #1;
      ext1 = 1'b1;
      repeat (2) @(posedge sync_clk);
      #1;
      ext1 = 1'b0;
      cyc(5);
      gs(16'h1234, 16'h1234);
      wr(1'b1, `IMF_OFS_SYNC_CFG, 8'h30);
      cyc(2);
      chk({14'h0000, g2e, g1e}, 16'h0001, "sync pin two");
      ext2 = 1'b1;
      cyc(5);
      gs(16'hFFFE, 16'hFFFF);
      wr(1'b1, QC, 8'h00);
      gs(16'hFFFE, 16'hFFFE);
      wr(1'b1, QC, 8'h40);
      gs(16'hFFFE, 16'hFFFF);
      wr(1'b1, `IMF_OFS_SYNC_CFG, 8'h00);
      cyc(2);
      chk({15'h0000, g2e}, 16'h0001, "sync off oe");
      gs(16'hFFFE, 16'hFFFE);
      ext2 = 1'b0;
   endtask
   // hang guard
   initial
   begin
      #100000;
      err_count++;
      end_sim();
   end
   // main sequence
   initial
   begin
      cyc(3);
      srst = 1'b0;
      t_reset();
      t_gyro_stop();
      t_acc_modes();
      t_acc_pins();
      t_gyro_pins();
      t_sync();
      end_sim();
   end
endmodule
`default_nettype wire
